//--- shared/csr_defines.svh
// Constants for the chip select, refresh and strap pin block
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// ==================================================
// Register word offsets
`define CSR_OFS_AUX 4'h0
`define CSR_OFS_DYN 4'h1
`define CSR_OFS_MPAUX 4'h2
`define CSR_OFS_LOWER 4'h3
`define CSR_OFS_UPPER 4'h4
`define CSR_OFS_MIDBASE 4'h5
`define CSR_OFS_PERBASE 4'h6
`define CSR_OFS_GPIO 4'h7
`define CSR_OFS_STATUS 4'h8

// ==================================================
// Field positions
`define CSR_AUX_WIDE_BIT 1
`define CSR_DYN_MODE_BIT 15
`define CSR_DYN_PSRAM_BIT 14
`define CSR_MP_PINSEL_BIT 7
`define CSR_MP_WHOLE_BIT 6
`define CSR_LU_ADDRDIS_BIT 7
`define CSR_LU_ENABLE_BIT 0
`define CSR_PER_IO_BIT 15

// ==================================================
// Reset values
`define CSR_RST_AUX 16'h0000
`define CSR_RST_DYN 16'h0000
`define CSR_RST_MPAUX 16'h0080
`define CSR_RST_LOWER 16'h0000
`define CSR_RST_UPPER 16'hF001
`define CSR_RST_MIDBASE 16'h0080
`define CSR_RST_PERBASE 16'h0000
`define CSR_RST_GPIO 16'h0007
`define CSR_EXEC_ADDR 20'hF_FFF0

// ==================================================
// Timing: output clock is sys_clk divided by two, times in tenths of it
`define CSR_OUTCLK_DIV 2
`define CSR_RFSH_LOW_TENTHS 15
`define CSR_FETCH_TENTHS 65
`define CSR_RFSH_LOW_CYC ((`CSR_RFSH_LOW_TENTHS * `CSR_OUTCLK_DIV + 9) / 10)
`define CSR_FETCH_CYC ((`CSR_FETCH_TENTHS * `CSR_OUTCLK_DIV + 9) / 10)
`define CSR_RFSH_TOTAL_CYC 8
`define CSR_STRAP_SAMPLE_CYC 3
`define CSR_PERIPH_REGIONS 7
`define CSR_PERIPH_HOLE 4

`endif

//--- shared/csr_pkg.sv
// Types shared by the chip select and refresh pin block
package csr_pkg;
    // Bus sequencer states, Gray along idle-address-turn-data
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_TURN = 3'h3,
        ST_DATA = 3'h2,
        ST_HOLD = 3'h6,
        ST_RFSH = 3'h4
    } csr_state_type;
endpackage

//--- rtl/csr_sync2.sv
// Two-stage synchroniser for one asynchronous level
module csr_sync2 #(
    parameter bit RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    logic stageOne;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stageOne <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end
endmodule

//--- rtl/csr_pins.sv
// Chip select, refresh strobe, latched address and strap pin logic
`include "csr_defines.svh"

module csr_pins (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // Bus cycle requests from the core
    input wire logic cycStart,
    input wire logic [19:0] cycAddr,
    input wire logic cycIo,
    input wire logic cycRead,
    input wire logic cycEnd,
    input wire logic onceMode,
    output logic busFree,
    output logic fetchStart,
    output logic [19:0] execAddr,
    // Bus hold handshake
    input wire logic holdReq,
    output logic holdAck,
    // Midrange selects and shared pins
    output logic midSelectFirst_b,
    output logic midSelectSecond_b,
    output logic midSelectThird_b,
    output logic midSelectFourth_b,
    output logic midWide,
    // Peripheral selects and latched address
    output logic [3:0] periphSelect_b,
    output logic periphSelectSixth_b,
    output logic periphSelectSeventh_b,
    // Read strobe and multiplexed bus control
    output logic rdStrobe_b,
    output logic rdStrobeOe,
    output logic adAddrDrive,
    // Secondary refresh and address-enable strap pin
    input wire logic addrEnableStrapIn,
    output logic secondaryRefreshStrobe_b,
    output logic secondaryRefreshOe
);
    import csr_pkg::*;

    csr_state_type state;
    csr_state_type next_state;
    logic [1:0] rstSync;
    logic intRst_b;
    logic holdSync;
    logic strapSync;
    logic strapHigh;
    logic [3:0] fetchCnt;
    logic [15:0] auxConfigReg, dynMemoryControlReg, midPeriphAuxReg;
    logic [15:0] lowerSelectReg, upperSelectReg, midBaseReg, periphBaseReg, gpioReg;
    logic [3:0] midHit, next_midHit;
    logic [6:0] perHit, next_perHit;
    logic [3:0] decMid;
    logic [6:0] decPer;
    logic decLu, decDaBit;
    logic cycRd, cycLuDrop;
    logic [1:0] latchedAddr;
    logic [8:0] refCnt;
    logic refreshDue;
    logic [2:0] rfCnt;
    logic next_rfshLow;
    logic addrPinSelectBit, wholeRange, dynMode, psramMode;
    logic [9:0] midOfs, midShift;
    logic [11:0] perOfs;

    assign intRst_b = rstSync[1];
    assign addrPinSelectBit = midPeriphAuxReg[`CSR_MP_PINSEL_BIT];
    assign wholeRange = midPeriphAuxReg[`CSR_MP_WHOLE_BIT];
    assign dynMode = dynMemoryControlReg[`CSR_DYN_MODE_BIT];
    assign psramMode = dynMemoryControlReg[`CSR_DYN_PSRAM_BIT];

    // ==================================================
    // Reset and strap synchronisation
    // Reset asserts at once, releases through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    csr_sync2 #(.RESET_VAL(1'b0)) uHoldSync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .asyncIn(holdReq),
        .syncOut(holdSync)
    );

    csr_sync2 #(.RESET_VAL(1'b1)) uStrapSync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .asyncIn(addrEnableStrapIn),
        .syncOut(strapSync)
    );

    // Fetch delay counter and restart address
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetchCnt <= 4'h0;
            fetchStart <= 1'b0;
            execAddr <= `CSR_EXEC_ADDR;
        end else begin
            if (fetchCnt != 4'(`CSR_FETCH_CYC)) begin
                fetchCnt <= fetchCnt + 4'h1;
            end
            fetchStart <= (fetchCnt == 4'(`CSR_FETCH_CYC - 1));
            execAddr <= `CSR_EXEC_ADDR;
        end
    end

    // Strap caught once, reflecting the pin two cycles after release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strapHigh <= 1'b1;
        end else if (fetchCnt == 4'(`CSR_STRAP_SAMPLE_CYC)) begin
            strapHigh <= strapSync;
        end
    end

    // ==================================================
    // Register file
    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            auxConfigReg <= `CSR_RST_AUX;
            dynMemoryControlReg <= `CSR_RST_DYN;
            midPeriphAuxReg <= `CSR_RST_MPAUX;
            lowerSelectReg <= `CSR_RST_LOWER;
            upperSelectReg <= `CSR_RST_UPPER;
            midBaseReg <= `CSR_RST_MIDBASE;
            periphBaseReg <= `CSR_RST_PERBASE;
            gpioReg <= `CSR_RST_GPIO;
        end else if (regWr) begin
            unique case (regAddr)
                `CSR_OFS_AUX: auxConfigReg <= regWrData;
                `CSR_OFS_DYN: dynMemoryControlReg <= regWrData;
                `CSR_OFS_MPAUX: midPeriphAuxReg <= regWrData;
                `CSR_OFS_LOWER: lowerSelectReg <= regWrData;
                `CSR_OFS_UPPER: upperSelectReg <= regWrData;
                `CSR_OFS_MIDBASE: midBaseReg <= regWrData;
                `CSR_OFS_PERBASE: periphBaseReg <= regWrData;
                `CSR_OFS_GPIO: gpioReg <= regWrData;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            regRdData <= 16'h0000;
        end else if (!regRd) begin
            regRdData <= 16'h0000;
        end else begin
            unique case (regAddr)
                `CSR_OFS_AUX: regRdData <= auxConfigReg;
                `CSR_OFS_DYN: regRdData <= dynMemoryControlReg;
                `CSR_OFS_MPAUX: regRdData <= midPeriphAuxReg;
                `CSR_OFS_LOWER: regRdData <= lowerSelectReg;
                `CSR_OFS_UPPER: regRdData <= upperSelectReg;
                `CSR_OFS_MIDBASE: regRdData <= midBaseReg;
                `CSR_OFS_PERBASE: regRdData <= periphBaseReg;
                `CSR_OFS_GPIO: regRdData <= gpioReg;
                `CSR_OFS_STATUS: regRdData <= {8'h00, refreshDue, strapHigh, holdAck,
                    2'h0, state};
                default: regRdData <= 16'h0000;
            endcase
        end
    end

    // ==================================================
    // Address decode of a starting cycle
    always_comb begin
        midOfs = cycAddr[19:10] - midBaseReg[9:0];
        midShift = midOfs >> midPeriphAuxReg[2:0];
        perOfs = cycAddr[19:8] - periphBaseReg[11:0];
        decLu = 1'b0;
        decDaBit = 1'b0;
        decMid = 4'h0;
        decPer = 7'h00;
        if (!cycIo && upperSelectReg[`CSR_LU_ENABLE_BIT]
            && cycAddr[19:12] >= upperSelectReg[15:8]) begin
            decLu = 1'b1;
            decDaBit = upperSelectReg[`CSR_LU_ADDRDIS_BIT];
        end else if (!cycIo && lowerSelectReg[`CSR_LU_ENABLE_BIT]
            && cycAddr[19:12] <= lowerSelectReg[15:8]) begin
            decLu = 1'b1;
            decDaBit = lowerSelectReg[`CSR_LU_ADDRDIS_BIT];
        end
        // Lower and upper win, then midrange, then peripheral
        if (!decLu && !cycIo && midShift < 10'h004) begin
            decMid[wholeRange ? 2'h0 : midShift[1:0]] = 1'b1;
        end else if (!decLu && (cycIo == periphBaseReg[`CSR_PER_IO_BIT])
            && perOfs < 12'(`CSR_PERIPH_REGIONS)
            && perOfs != 12'(`CSR_PERIPH_HOLE)) begin
            decPer[perOfs[2:0]] = 1'b1;
        end
    end

    // ==================================================
    // Bus sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (cycStart) begin
                    next_state = ST_ADDR;
                end else if (refreshDue) begin
                    next_state = ST_RFSH;
                end else if (holdSync) begin
                    next_state = ST_HOLD;
                end
            end
            ST_ADDR: next_state = ST_TURN;
            ST_TURN: next_state = ST_DATA;
            ST_DATA: begin
                if (cycEnd) begin
                    next_state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (!holdSync) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RFSH: begin
                if (rfCnt == 3'(`CSR_RFSH_TOTAL_CYC - 1)) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Selects load at cycle start, clear at cycle end or hold
    always_comb begin
        next_midHit = midHit;
        next_perHit = perHit;
        if (state == ST_IDLE && cycStart) begin
            next_midHit = decMid;
            next_perHit = decPer;
        end else if (next_state != ST_ADDR && next_state != ST_TURN
            && next_state != ST_DATA) begin
            next_midHit = 4'h0;
            next_perHit = 7'h00;
        end
    end

    // Cycle attributes held for the whole cycle
    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            midHit <= 4'h0;
            perHit <= 7'h00;
            cycRd <= 1'b0;
            cycLuDrop <= 1'b0;
            latchedAddr <= 2'h0;
        end else begin
            midHit <= next_midHit;
            perHit <= next_perHit;
            if (state == ST_IDLE && cycStart) begin
                cycRd <= cycRead;
                cycLuDrop <= decLu && decDaBit && strapHigh;
                latchedAddr <= cycAddr[2:1];
            end
        end
    end

    // ==================================================
    // Refresh timer and refresh cycle
    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            refCnt <= 9'h000;
            refreshDue <= 1'b0;
        end else if (!dynMode) begin
            refCnt <= dynMemoryControlReg[8:0];
            refreshDue <= 1'b0;
        end else begin
            refCnt <= (refCnt == 9'h000) ? dynMemoryControlReg[8:0] : refCnt - 9'h001;
            // A new expiry wins over the service of the old one
            if (refCnt == 9'h000) begin
                refreshDue <= 1'b1;
            end else if (state == ST_IDLE && next_state == ST_RFSH) begin
                refreshDue <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            rfCnt <= 3'h0;
        end else if (next_state == ST_RFSH && state == ST_RFSH) begin
            rfCnt <= rfCnt + 3'h1;
        end else begin
            rfCnt <= 3'h0;
        end
    end

    // Low for the first cycles of the refresh cycle only
    assign next_rfshLow = (next_state == ST_RFSH)
        && (state != ST_RFSH || rfCnt < 3'(`CSR_RFSH_LOW_CYC - 1));

    // ==================================================
    // Pin registers
    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            midSelectFirst_b <= 1'b1;
            midSelectSecond_b <= 1'b1;
            midSelectThird_b <= 1'b1;
            midSelectFourth_b <= 1'b1;
            midWide <= 1'b0;
        end else begin
            midSelectFirst_b <= !next_midHit[0];
            midSelectSecond_b <= wholeRange ? gpioReg[0] : !next_midHit[1];
            midSelectThird_b <= wholeRange ? gpioReg[1] : !next_midHit[2];
            if (dynMode) begin
                midSelectFourth_b <= !next_rfshLow;
            end else begin
                midSelectFourth_b <= wholeRange ? gpioReg[2] : !next_midHit[3];
            end
            midWide <= auxConfigReg[`CSR_AUX_WIDE_BIT] && (next_midHit != 4'h0);
        end
    end

    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            periphSelect_b <= 4'hF;
            periphSelectSixth_b <= 1'b1;
            periphSelectSeventh_b <= 1'b1;
        end else begin
            periphSelect_b <= ~next_perHit[3:0];
            if (addrPinSelectBit) begin
                periphSelectSixth_b <= !next_perHit[5];
                periphSelectSeventh_b <= !next_perHit[6];
            end else begin
                periphSelectSixth_b <= (state == ST_IDLE && cycStart) ? cycAddr[1]
                    : latchedAddr[0];
                periphSelectSeventh_b <= (state == ST_IDLE && cycStart) ? cycAddr[2]
                    : latchedAddr[1];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge intRst_b) begin
        if (!intRst_b) begin
            rdStrobe_b <= 1'b1;
            rdStrobeOe <= 1'b1;
            adAddrDrive <= 1'b0;
            holdAck <= 1'b0;
            busFree <= 1'b0;
            secondaryRefreshStrobe_b <= 1'b1;
            secondaryRefreshOe <= 1'b0;
        end else begin
            rdStrobe_b <= !(next_state == ST_DATA && (state == ST_DATA ? cycRd : 1'b1)
                && cycRd);
            rdStrobeOe <= (next_state != ST_HOLD);
            adAddrDrive <= (next_state == ST_ADDR)
                && !(decLu && decDaBit && strapHigh);
            holdAck <= (next_state == ST_HOLD);
            busFree <= (next_state == ST_IDLE) && (fetchCnt == 4'(`CSR_FETCH_CYC));
            secondaryRefreshStrobe_b <= !(next_rfshLow && !psramMode);
            secondaryRefreshOe <= (fetchCnt > 4'(`CSR_STRAP_SAMPLE_CYC))
                && (next_state != ST_HOLD) && !onceMode;
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!intRst_b);

    sequence s_rfshLow;
        !midSelectFourth_b [*3];
    endsequence

    property p_midHold;
        holdAck && !wholeRange && !dynMode |-> midSelectFirst_b && midSelectSecond_b
            && midSelectThird_b && midSelectFourth_b;
    endproperty
    a_midHold: assert property (p_midHold) else $error("midrange select low in hold");

    property p_rfshPulse;
        dynMode && $fell(midSelectFourth_b) |-> s_rfshLow ##1 midSelectFourth_b;
    endproperty
    a_rfshPulse: assert property (p_rfshPulse) else $error("refresh pulse width wrong");

    property p_perHold;
        holdAck |-> (periphSelect_b == 4'hF) && (!addrPinSelectBit
            || (periphSelectSixth_b && periphSelectSeventh_b));
    endproperty
    a_perHold: assert property (p_perHold) else $error("peripheral select low in hold");

    property p_rdTurn;
        $fell(rdStrobe_b) |-> !adAddrDrive && !$past(adAddrDrive);
    endproperty
    a_rdTurn: assert property (p_rdTurn) else $error("read strobe before turnaround");

    property p_rdFloat;
        holdAck |-> !rdStrobeOe && !secondaryRefreshOe;
    endproperty
    a_rdFloat: assert property (p_rdFloat) else $error("pin driven during hold");

    property p_oneSelect;
        $countones({~periphSelect_b, !midSelectFirst_b,
            !wholeRange && !midSelectSecond_b, !wholeRange && !midSelectThird_b}) <= 1;
    endproperty
    a_oneSelect: assert property (p_oneSelect) else $error("two selects low at once");

    property p_addrKeep;
        holdAck && $past(holdAck) && !addrPinSelectBit && !$past(addrPinSelectBit)
            |-> $stable(periphSelectSixth_b) && $stable(periphSelectSeventh_b);
    endproperty
    a_addrKeep: assert property (p_addrKeep) else $error("latched address moved in hold");

    property p_holdGrant;
        holdSync && state == ST_IDLE && !cycStart && !refreshDue |=> holdAck;
    endproperty
    a_holdGrant: assert property (p_holdGrant) else $error("hold not granted when idle");

    property p_rfsh2Psram;
        !secondaryRefreshStrobe_b |-> !psramMode && dynMode;
    endproperty
    a_rfsh2Psram: assert property (p_rfsh2Psram) else $error("secondary refresh in psram");
endmodule

//--- tb/csr_far_side.sv
// Far-side model: external bus master and refresh pulse counter
module csr_far_side (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Bench control and observed pin
    input wire logic holdWant,
    input wire logic fourthPin_b,
    // Hold request and refresh count
    output logic holdReq,
    output int rfshPulses
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lastFourth;
    // Request and withdraw the bus just after an edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) holdReq <= 1'b0;
        else holdReq <= holdWant;
    end
    // Count falling refresh strobes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lastFourth <= 1'b1;
            rfshPulses <= 0;
        end else begin
            lastFourth <= fourthPin_b;
            if (lastFourth && !fourthPin_b) rfshPulses <= rfshPulses + 1;
        end
    end
endmodule

//--- tb/csr_pins_bench.sv
// Bench for the chip select, refresh and strap pin block
module csr_pins_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import csr_pkg::*;
    logic sys_clk = 0, rst_b = 0, regWr = 0, regRd = 0, cycStart = 0, cycIo = 0;
    logic cycRead = 0, cycEnd = 0, holdWant = 0, holdReq, addrEnableStrapIn = 1, onceMode = 0;
    logic [3:0] regAddr = 0, periphSelect_b;
    logic [15:0] regWrData = 0, regRdData;
    logic [19:0] cycAddr = 0, execAddr;
    logic busFree, fetchStart, holdAck, midSelectFirst_b, midSelectSecond_b;
    logic midSelectThird_b, midSelectFourth_b, midWide, periphSelectSixth_b;
    logic periphSelectSeventh_b, rdStrobe_b, rdStrobeOe, adAddrDrive;
    logic secondaryRefreshStrobe_b, secondaryRefreshOe;
    int mismatches = 0, n_tests = 0, n, rfshPulses;
    wire logic [9:0] sels = {midSelectFirst_b, midSelectSecond_b, midSelectThird_b,
        midSelectFourth_b, periphSelect_b, periphSelectSixth_b, periphSelectSeventh_b};
    // Design and far side
    csr_pins u_csr_pins (.sys_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .cycStart, .cycAddr, .cycIo, .cycRead, .cycEnd, .onceMode,
        .busFree, .fetchStart, .execAddr, .holdReq, .holdAck, .midSelectFirst_b,
        .midSelectSecond_b, .midSelectThird_b, .midSelectFourth_b, .midWide,
        .periphSelect_b, .periphSelectSixth_b, .periphSelectSeventh_b, .rdStrobe_b,
        .rdStrobeOe, .adAddrDrive, .addrEnableStrapIn, .secondaryRefreshStrobe_b,
        .secondaryRefreshOe);
    csr_far_side u_csr_far_side (.sys_clk, .rst_b, .holdWant,
        .fourthPin_b(midSelectFourth_b), .holdReq, .rfshPulses);
    // Clock
    initial forever #5 sys_clk = ~sys_clk;
    // Compare, count and report
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWr <= 1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 0;
        #1 chk("regRdData", regRdData, exp);
    endtask
    // One read bus cycle with expected pins in the first and third cycles
    task automatic cyc(input logic [19:0] a, input logic io, input logic [9:0] es,
        input logic ad, input logic ew);
        @(posedge sys_clk);
        cycStart <= 1;
        cycAddr <= a;
        cycIo <= io;
        cycRead <= 1;
        @(posedge sys_clk);
        cycStart <= 0;
        #1 chk("sels", sels, es);
        chk("adAddrDrive", adAddrDrive, ad);
        chk("midWide", midWide, ew);
        tick();
        chk("turn", adAddrDrive, 0);
        tick();
        chk("rdStrobe_b", rdStrobe_b, 0);
        @(posedge sys_clk);
        cycEnd <= 1;
        @(posedge sys_clk);
        cycEnd <= 0;
        #1 chk("selsEnd", sels[9:2], 8'hFF);
        chk("busFree", busFree, 1);
    endtask
    // Cut a hang short
    initial begin
        #200us;
        mismatches++;
        results();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 chk("selsRst", sels, 10'h3FF);
        chk("exec", execAddr, 20'hF_FFF0);
        @(posedge sys_clk);
        rst_b <= 1;
        for (n = 1; n < 40; n++) begin
            tick();
            if (fetchStart === 1'b1) break;
        end
        chk("fetchDelay", n, 13);
        tick();
        rd(0, 16'h0000);
        rd(1, 16'h0000);
        rd(2, 16'h0080);
        rd(4, 16'hF001);
        rd(5, 16'h0080);
        rd(7, 16'h0007);
        wr(8, 16'hFFFF);
        rd(8, 16'h0040);
        rd(9, 16'h0000);
        wr(0, 16'h0002);
        wr(6, 16'h0100);
        cyc(20'h2_0000, 0, 10'h1FF, 1, 1);
        cyc(20'h1_0500, 0, 10'h3FD, 1, 0);
        cyc(20'h1_0400, 0, 10'h3FF, 1, 0);
        cyc(20'h3_0000, 0, 10'h3FF, 1, 0);
        wr(6, 16'h8100);
        cyc(20'h1_0000, 1, 10'h3FB, 1, 0);
        wr(2, 16'h0000);
        cyc(20'h1_0002, 1, 10'h3FA, 1, 0);
        holdWant <= 1;
        for (n = 0; n < 12 && holdAck !== 1'b1; n++) tick();
        chk("holdAck", holdAck, 1);
        chk("selsHold", sels, 10'h3FE);
        chk("rdOe", rdStrobeOe, 0);
        chk("secOe", secondaryRefreshOe, 0);
        holdWant <= 0;
        for (n = 0; n < 12 && holdAck !== 1'b0; n++) tick();
        chk("holdDrop", holdAck, 0);
        chk("secOeBack", secondaryRefreshOe, 1);
        @(posedge sys_clk);
        onceMode <= 1;
        tick();
        chk("secOnce", secondaryRefreshOe, 0);
        @(posedge sys_clk);
        onceMode <= 0;
        wr(2, 16'h00C0);
        wr(7, 16'h0006);
        tick();
        chk("gpio", {midSelectSecond_b, midSelectThird_b}, 2'b01);
        wr(1, 16'h8010);
        for (n = 0; n < 100 && midSelectFourth_b !== 1'b0; n++) tick();
        chk("sec_b", secondaryRefreshStrobe_b, 0);
        for (n = 0; n < 10 && midSelectFourth_b === 1'b0; n++) tick();
        chk("rfshLow", n, 3);
        chk("pulses", rfshPulses, 1);
        wr(1, 16'hC010);
        for (n = 0; n < 100 && midSelectFourth_b !== 1'b0; n++) tick();
        chk("psram", secondaryRefreshStrobe_b, 1);
        wr(1, 16'h0000);
        repeat (60) tick();
        chk("noRfsh", rfshPulses, 2);
        wr(2, 16'h0080);
        wr(3, 16'h0081);
        cyc(20'h0_0100, 0, 10'h3FF, 0, 0);
        // Second reset with the strap low keeps the address on the muxed bus
        @(posedge sys_clk);
        rst_b <= 0;
        addrEnableStrapIn <= 0;
        tick();
        chk("selsRst2", sels, 10'h3FF);
        chk("exec2", execAddr, 20'hF_FFF0);
        repeat (2) @(posedge sys_clk);
        rst_b <= 1;
        repeat (16) tick();
        rd(8, 16'h0000);
        wr(3, 16'h0081);
        cyc(20'h0_0100, 0, 10'h3FF, 1, 0);
        results();
    end
endmodule
